// File: shared/rtcd_pkg.sv
// Constants shared by the clock divider, rate selector, interrupt logic and user RAM.
// Assumes a single clock domain; the time base arrives as a one-cycle tick.
package rtcd_pkg;

  // ---------------------------------------------------------------
  // Divider chain
  // ---------------------------------------------------------------
  localparam int DIV_STAGES = 22;
  localparam logic [2:0] DVS_HIGH = 3'h0;
  localparam logic [2:0] DVS_MID = 3'h1;
  localparam logic [2:0] DVS_LOW = 3'h2;
  localparam logic [2:0] DVS_HOLD_A = 3'h6;
  localparam logic [2:0] DVS_HOLD_B = 3'h7;
  localparam int BYPASS_HIGH = 0;
  localparam int BYPASS_MID = 2;
  localparam int BYPASS_LOW = 7;
  localparam logic [4:0] ONE_HZ_STAGE = 5'h15;

  // ---------------------------------------------------------------
  // Rate selector
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_SHARED_FIRST = 4'h3;
  localparam logic [4:0] TAP_OFS_HIGH = 5'h05;
  localparam logic [4:0] TAP_OFS_LOW = 5'h0c;

  // ---------------------------------------------------------------
  // Control word, enable word and flag word layouts
  // ---------------------------------------------------------------
  localparam int SEL_W = 7;
  localparam int SEL_DIV_LSB = 4;
  localparam logic [6:0] SEL_RESET = 7'h60;
  localparam int EN_W = 4;
  localparam int EN_PERIODIC = 3;
  localparam int EN_ALARM = 2;
  localparam int EN_UPDATE = 1;
  localparam int EN_SQW = 0;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam int FLG_SUMMARY = 7;
  localparam int FLG_PERIODIC = 6;
  localparam int FLG_ALARM = 5;
  localparam int FLG_UPDATE = 4;
  localparam int SRC_N = 3;

  // ---------------------------------------------------------------
  // User RAM map
  // ---------------------------------------------------------------
  localparam int RAM_AW = 6;
  localparam logic [5:0] SECONDS_ADDR = 6'h00;
  localparam logic [5:0] TIME_LAST = 6'h09;
  localparam logic [5:0] CTRL_FIRST = 6'h0a;
  localparam logic [5:0] CTRL_LAST = 6'h0d;
  localparam logic [7:0] SECONDS_MASK = 8'h7f;
  localparam logic [7:0] FULL_MASK = 8'hff;

endpackage : rtcd_pkg

// File: hw/rtcd_ram.sv
// Byte-wide storage for the user RAM locations.
// Assumes the caller gates writes and masks; read data comes from a register.
`timescale 1ns/1ns
module rtcd_ram #(
  parameter int AW = 6,
  parameter int DEPTH = 64
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rd_zero,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // Control and status locations are not storage and read back as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_zero ? 8'h00 : mem[addr];
    end
  end

endmodule : rtcd_ram

// File: hw/rtcd_core.sv
// Time-base divider, rate selector, square-wave pin, interrupt flags and user RAM port.
// Assumes all inputs are synchronous to clock; time_base_tick pulses once per
// time-base cycle; alarm and update-ended events come from outside as pulses.
`timescale 1ns/1ns

module rtcd_core #(
  parameter int DIV_W = rtcd_pkg::DIV_STAGES,
  parameter int RAM_DEPTH = 64
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic dev_reset,
  input wire logic time_base_tick,
  input wire logic alarm_event,
  input wire logic update_ended_event,
  input wire logic sel_write,
  input wire logic [rtcd_pkg::SEL_W-1:0] sel_wdata,
  input wire logic en_write,
  input wire logic [rtcd_pkg::EN_W-1:0] en_wdata,
  input wire logic flag_read,
  input wire logic ram_wr,
  input wire logic [rtcd_pkg::RAM_AW-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [rtcd_pkg::SEL_W-1:0] sel_value,
  output logic [rtcd_pkg::EN_W-1:0] en_value,
  output logic [7:0] flag_value,
  output logic irq_n,
  output logic square_wave_pin,
  output logic one_hz_tick,
  output logic divider_held,
  output logic [7:0] ram_rdata
);

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  logic [2:0] divider_select;
  logic [3:0] rate_select;
  logic periodic_irq_enable;
  logic alarm_irq_enable;
  logic update_irq_enable;
  logic square_wave_enable;

  assign divider_select = sel_value[rtcd_pkg::SEL_DIV_LSB +: 3];
  assign rate_select = sel_value[3:0];
  assign periodic_irq_enable = en_value[rtcd_pkg::EN_PERIODIC];
  assign alarm_irq_enable = en_value[rtcd_pkg::EN_ALARM];
  assign update_irq_enable = en_value[rtcd_pkg::EN_UPDATE];
  assign square_wave_enable = en_value[rtcd_pkg::EN_SQW];

  // Only power-on resets the selection to SEL_RESET; the device reset leaves it alone
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_value <= rtcd_pkg::SEL_RESET;
    end else if (sel_write) begin
      sel_value <= sel_wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_value <= rtcd_pkg::EN_RESET;
    end else if (dev_reset) begin
      en_value <= rtcd_pkg::EN_RESET;
    end else if (en_write) begin
      en_value <= en_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Divider chain
  // ---------------------------------------------------------------
  logic run_high;
  logic run_mid;
  logic run_low;
  logic next_held;
  logic [DIV_W-1:0] div_step;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] next_div;
  logic div_top_prev;

  assign run_high = divider_select == rtcd_pkg::DVS_HIGH;
  assign run_mid = divider_select == rtcd_pkg::DVS_MID;
  assign run_low = divider_select == rtcd_pkg::DVS_LOW;
  // Test codes are not supported, so they hold the chain like the reset codes
  assign next_held = !(run_high || run_mid || run_low);
  // Bypassing N stages is the same as counting in steps of two to the N
  assign div_step = run_low ? DIV_W'(1 << rtcd_pkg::BYPASS_LOW) :
                    run_mid ? DIV_W'(1 << rtcd_pkg::BYPASS_MID) :
                    DIV_W'(1 << rtcd_pkg::BYPASS_HIGH);
  assign next_div = next_held ? '0 :
                    time_base_tick ? div + div_step : div;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div <= '0;
      divider_held <= 1'b1;
      div_top_prev <= 1'b0;
    end else begin
      div <= next_div;
      divider_held <= next_held;
      div_top_prev <= div[rtcd_pkg::ONE_HZ_STAGE];
    end
  end

  // The top stage rises half a second after release and once a second after
  logic next_one_hz;
  assign next_one_hz = div[rtcd_pkg::ONE_HZ_STAGE] && !div_top_prev;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      one_hz_tick <= 1'b0;
    end else begin
      one_hz_tick <= next_one_hz;
    end
  end

  // ---------------------------------------------------------------
  // Rate selector and square wave
  // ---------------------------------------------------------------
  logic [4:0] tap_idx;
  logic tap;
  logic tap_prev;
  logic rate_on;
  logic periodic_ev;
  logic next_sqw;

  // Low base shifts the two fastest codes down to 256 Hz and 128 Hz
  assign tap_idx = (run_low && rate_select < rtcd_pkg::RATE_SHARED_FIRST) ?
                   5'(rate_select) + rtcd_pkg::TAP_OFS_LOW :
                   5'(rate_select) + rtcd_pkg::TAP_OFS_HIGH;
  assign tap = div[tap_idx];
  assign rate_on = rate_select != rtcd_pkg::RATE_NONE && !divider_held;
  // A selection change may make one short edge; that is tolerated
  assign periodic_ev = rate_on && tap && !tap_prev;
  assign next_sqw = rate_on && square_wave_enable && tap;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tap_prev <= 1'b0;
      square_wave_pin <= 1'b0;
    end else begin
      tap_prev <= tap;
      square_wave_pin <= next_sqw;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------
  logic [rtcd_pkg::SRC_N-1:0] src_ev;
  logic [rtcd_pkg::SRC_N-1:0] src_en;
  logic [rtcd_pkg::SRC_N-1:0] flag;
  logic [rtcd_pkg::SRC_N-1:0] pend;
  logic [rtcd_pkg::SRC_N-1:0] next_flag;
  logic [rtcd_pkg::SRC_N-1:0] next_pend;
  logic irq_active;
  logic [7:0] snap;

  // Bit order: periodic, alarm, update ended
  assign src_ev = {periodic_ev, alarm_event, update_ended_event};
  assign src_en = {periodic_irq_enable, alarm_irq_enable, update_irq_enable};
  assign irq_active = |(flag & src_en);
  // Events landing in the read cycle wait one cycle so they are never lost
  assign next_pend = flag_read ? src_ev : '0;
  // Events deferred by the previous read were not returned, so this read keeps them
  assign next_flag = flag_read ? pend : (flag | pend | src_ev);

  always_comb begin
    snap = 8'h00;
    snap[rtcd_pkg::FLG_SUMMARY] = irq_active;
    snap[rtcd_pkg::FLG_PERIODIC] = flag[2];
    snap[rtcd_pkg::FLG_ALARM] = flag[1];
    snap[rtcd_pkg::FLG_UPDATE] = flag[0];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag <= '0;
      pend <= '0;
    end else if (dev_reset) begin
      flag <= '0;
      pend <= '0;
    end else begin
      flag <= next_flag;
      pend <= next_pend;
    end
  end

  // Read value is captured once and stands until the next read
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_value <= 8'h00;
    end else if (flag_read) begin
      flag_value <= snap;
    end
  end

  // Enable changes act on the next edge, with no event needed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_n <= 1'b1;
    end else if (dev_reset) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !irq_active;
    end
  end

  // ---------------------------------------------------------------
  // User RAM
  // ---------------------------------------------------------------
  logic addr_ctrl;
  logic addr_time;
  logic ram_we;
  logic [7:0] ram_wmasked;

  assign addr_ctrl = ram_addr >= rtcd_pkg::CTRL_FIRST && ram_addr <= rtcd_pkg::CTRL_LAST;
  assign addr_time = ram_addr <= rtcd_pkg::TIME_LAST;
  // User bytes never lock; time bytes are storage only while the chain is held
  assign ram_we = ram_wr && !addr_ctrl && (!addr_time || divider_held);
  assign ram_wmasked = ram_wdata & ((ram_addr == rtcd_pkg::SECONDS_ADDR) ?
                       rtcd_pkg::SECONDS_MASK : rtcd_pkg::FULL_MASK);

  rtcd_ram #(
    .AW(rtcd_pkg::RAM_AW),
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .clock(clock),
    .nrst(nrst),
    .wr_en(ram_we),
    .addr(ram_addr),
    .wdata(ram_wmasked),
    .rd_zero(addr_ctrl),
    .rdata(ram_rdata)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst || dev_reset);

  sequence s_read_with_alarm;
    flag_read && alarm_event ##1 !flag_read;
  endsequence

  a_held_no_wave: assert property (
    divider_held |=> !square_wave_pin)
    else $error("square wave runs while divider held");

  a_held_no_periodic: assert property (
    divider_held |-> !periodic_ev)
    else $error("periodic event while divider held");

  a_flag_sets_always: assert property (
    periodic_ev && !flag_read |=> flag[2])
    else $error("periodic flag not set by event");

  a_read_clears_all: assert property (
    flag_read && src_ev == '0 |=> flag == $past(pend) && pend == '0)
    else $error("flag read did not clear flags");

  a_read_defers_event: assert property (
    s_read_with_alarm |=> flag[1])
    else $error("event during read was lost");

  a_enable_late_flag: assert property (
    en_write && !flag_read && (flag & {en_wdata[rtcd_pkg::EN_PERIODIC],
    en_wdata[rtcd_pkg::EN_ALARM], en_wdata[rtcd_pkg::EN_UPDATE]}) != '0 |-> ##2 !irq_n)
    else $error("request not raised for already set flag");

  a_request_follows: assert property (
    |(flag & src_en) && !flag_read && !en_write |=> !irq_n)
    else $error("request not asserted for enabled flag");

  a_summary_bit: assert property (
    flag_read |=> flag_value[rtcd_pkg::FLG_SUMMARY] == !irq_n)
    else $error("summary bit disagrees with request");

  a_rate_zero_off: assert property (
    rate_select == rtcd_pkg::RATE_NONE |-> !periodic_ev ##1 !square_wave_pin)
    else $error("rate zero still produces output");

  a_tick_top_stage: assert property (
    $rose(div[rtcd_pkg::ONE_HZ_STAGE]) |=> one_hz_tick ##1 !one_hz_tick)
    else $error("one second tick missing");

  a_release_restart: assert property (
    $fell(divider_held) |-> $past(div) == '0 && !one_hz_tick)
    else $error("divider not restarted from zero");

  a_low_bypass: assert property (
    run_low && !divider_held |=>
      div[rtcd_pkg::BYPASS_LOW-1:0] == $past(div[rtcd_pkg::BYPASS_LOW-1:0]))
    else $error("bypassed stages moved");

  a_wave_enable: assert property (
    !square_wave_enable && !en_write |=> !square_wave_pin)
    else $error("square wave without enable");

endmodule : rtcd_core

// File: sim/rtcd_host.sv
// Host processor model: services the request line by reading the flag word.
// Assumes the flag read pulse is ORed with the bench's own reads.
`timescale 1ns/1ns
module rtcd_host (
  input wire logic clock,
  input wire logic nrst,
  input wire logic irq_n,
  input wire logic [7:0] flag_value,
  input wire logic auto_en,
  input wire logic [3:0] lat,
  output logic flag_rd,
  output logic [7:0] seen,
  output logic [7:0] serviced
);
  logic [3:0] wait_cnt;
  logic [1:0] phase;
  // ---------------------------------------------------------------
  // Service routine
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
      wait_cnt <= 4'h0;
      flag_rd <= 1'b0;
      seen <= 8'h00;
      serviced <= 8'h00;
    end else begin
      flag_rd <= 1'b0;
      case (phase)
        2'h0: begin
          // Cool-down: the line is released only two cycles after the read
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (auto_en && !irq_n) begin
            phase <= 2'h1;
            wait_cnt <= lat;
          end
        end
        2'h1: begin
          if (wait_cnt == 4'h0) begin
            flag_rd <= 1'b1;
            phase <= 2'h2;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        2'h2: phase <= 2'h2 + 2'h1;
        default: begin
          seen <= seen | flag_value;
          serviced <= serviced + 8'h01;
          wait_cnt <= 4'h3;
          phase <= 2'h0;
        end
      endcase
    end
  end
endmodule : rtcd_host

// File: sim/rtcd_core_bench.sv
// Self-checking bench for the divider, rate selector, flags and user RAM.
// Assumes the time base ticks every cycle; the low base keeps 1 Hz short.
`timescale 1ns/1ns
module rtcd_core_bench;
  logic clock = 1'b0, nrst = 1'b0, dev_reset = 1'b0, time_base_tick = 1'b1;
  logic alarm_event = 1'b0, update_ended_event = 1'b0, bench_rd = 1'b0, host_rd;
  logic sel_write = 1'b0, en_write = 1'b0, ram_wr = 1'b0, auto_en = 1'b0;
  logic [6:0] sel_wdata = 7'h00, sel_value;
  logic [3:0] en_wdata = 4'h0, en_value, lat = 4'h0;
  logic [5:0] ram_addr = 6'h00;
  logic [7:0] ram_wdata = 8'h00, ram_rdata, flag_value, seen, serviced, tgt;
  logic irq_n, square_wave_pin, one_hz_tick, divider_held;
  int mismatches = 0, comparisons = 0, n;
  int tb_sel[4] = '{'h03, 'h13, 'h11, 'h01};
  int tb_per[4] = '{512, 128, 32, 128};
  rtcd_core i_dut (.clock(clock), .nrst(nrst), .dev_reset(dev_reset),
    .time_base_tick(time_base_tick), .alarm_event(alarm_event),
    .update_ended_event(update_ended_event), .sel_write(sel_write), .sel_wdata(sel_wdata),
    .en_write(en_write), .en_wdata(en_wdata), .flag_read(bench_rd | host_rd),
    .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .sel_value(sel_value),
    .en_value(en_value), .flag_value(flag_value), .irq_n(irq_n),
    .square_wave_pin(square_wave_pin), .one_hz_tick(one_hz_tick),
    .divider_held(divider_held), .ram_rdata(ram_rdata));
  rtcd_host i_host (.clock(clock), .nrst(nrst), .irq_n(irq_n), .flag_value(flag_value),
    .auto_en(auto_en), .lat(lat), .flag_rd(host_rd), .seen(seen), .serviced(serviced));
  initial begin
    forever #5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task sel(input logic [6:0] v);
    @(posedge clock);
    sel_write <= 1'b1;
    sel_wdata <= v;
    @(posedge clock);
    sel_write <= 1'b0;
    step(2);
  endtask : sel
  task en(input logic [3:0] v);
    @(posedge clock);
    en_write <= 1'b1;
    en_wdata <= v;
    @(posedge clock);
    en_write <= 1'b0;
    step(1);
  endtask : en
  // Bits: alarm, update, flag read, device reset
  task pulse(input logic [3:0] k);
    @(posedge clock);
    alarm_event <= k[0];
    update_ended_event <= k[1];
    bench_rd <= k[2];
    dev_reset <= k[3];
    @(posedge clock);
    alarm_event <= 1'b0;
    update_ended_event <= 1'b0;
    bench_rd <= 1'b0;
    dev_reset <= 1'b0;
    #1;
  endtask : pulse
  task rd(input logic [7:0] e);
    pulse(4'h4);
    step(1);
    chk(flag_value, e);
  endtask : rd
  task ram(input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clock);
    ram_wr <= 1'b1;
    ram_addr <= a;
    ram_wdata <= d;
    @(posedge clock);
    ram_wr <= 1'b0;
    step(2);
    chk(ram_rdata, e);
  endtask : ram
  function automatic bit sig(input int k);
    case (k)
      0: return irq_n === 1'b0;
      1: return one_hz_tick === 1'b1;
      2: return square_wave_pin === 1'b1;
      3: return square_wave_pin === 1'b0;
      default: return serviced === tgt;
    endcase
  endfunction : sig
  task wait_sig(input int k, input int lim, output int c);
    c = 0;
    do begin
      step(1);
      c++;
    end while (!sig(k) && c < lim);
    if (!sig(k)) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask : wait_sig
  task period(input int e);
    int a, b;
    // Two sync cycles skip the odd cycle a change may leave
    repeat (2) begin
      wait_sig(3, 600, a);
      wait_sig(2, 600, a);
    end
    wait_sig(3, 600, a);
    wait_sig(2, 600, b);
    chk(a + b, e);
  endtask : period
  task quiet(input int k);
    int ones;
    ones = 0;
    repeat (k) begin
      step(1);
      if (square_wave_pin !== 1'b0) ones++;
    end
    chk(ones, 0);
  endtask : quiet
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    step(1);
    chk(sel_value, 7'h60);
    chk(divider_held, 1'b1);
    ram(6'h00, 8'hff, 8'h7f);
    ram(6'h01, 8'h11, 8'h11);
    ram(6'h0a, 8'hff, 8'h00);
    sel(7'h23);
    chk(divider_held, 1'b0);
    ram(6'h20, 8'h55, 8'h55);
    ram(6'h01, 8'h22, 8'h11);
    en(4'h1);
    for (int r = 1; r <= 10; r++) begin
      sel(7'h20 | r[6:0]);
      period(r < 3 ? 64 << r : 1 << (r - 1));
    end
    for (int i = 0; i < 4; i++) begin
      sel(tb_sel[i][6:0]);
      period(tb_per[i]);
    end
    sel(7'h20);
    pulse(4'h4);
    quiet(60);
    rd(8'h00);
    en(4'h9);
    for (int c = 6; c < 8; c++) begin
      sel({c[2:0], 4'h3});
      pulse(4'h4);
      quiet(40);
      chk(divider_held, 1'b1);
      rd(8'h00);
    end
    sel(7'h2a);
    wait_sig(0, 600, n);
    rd(8'hc0);
    step(1);
    chk(irq_n, 1'b1);
    en(4'h1);
    step(600);
    chk(irq_n, 1'b1);
    rd(8'h40);
    sel(7'h20);
    pulse(4'h4);
    en(4'h0);
    pulse(4'h1);
    step(3);
    chk(irq_n, 1'b1);
    rd(8'h20);
    pulse(4'h2);
    en(4'h2);
    wait_sig(0, 3, n);
    rd(8'h90);
    step(1);
    chk(irq_n, 1'b1);
    en(4'h4);
    pulse(4'h5);
    step(1);
    chk(flag_value, 8'h00);
    wait_sig(0, 4, n);
    rd(8'ha0);
    en(4'h6);
    auto_en <= 1'b1;
    for (int l = 1; l <= 2; l++) begin
      lat <= (l == 1) ? 4'h0 : 4'h5;
      tgt <= l[7:0];
      pulse(4'h3);
      wait_sig(4, 30, n);
      chk(seen, 8'hb0);
      step(2);
      chk(irq_n, 1'b1);
    end
    auto_en <= 1'b0;
    pulse(4'h1);
    pulse(4'h8);
    chk(sel_value, 7'h20);
    chk(en_value, 4'h0);
    rd(8'h00);
    sel(7'h60);
    sel(7'h20);
    wait_sig(1, 16400, n);
    chk(n inside {[16383:16387]}, 1'b1);
    wait_sig(1, 32800, n);
    chk(n, 32768);
    report_and_stop();
  end
endmodule : rtcd_core_bench
